// File: hw/diag_flag_regs.vh
// register map, field positions and reset values of the diagnostic flag bank
`ifndef DIAG_FLAG_REGS_VH
`define DIAG_FLAG_REGS_VH

// ----------------------------------------------------------------------------
// register addresses and widths
// ----------------------------------------------------------------------------
`define ADDR_W                5
`define DATA_W                22
`define ANALOG_FLAGS_ADDR     5'h15
`define DIGITAL_FLAGS_ADDR    5'h14
`define ANALOG_FLAGS_RESET    22'h150000
`define DIGITAL_FLAGS_RESET   22'h140000

// ----------------------------------------------------------------------------
// common fields
// ----------------------------------------------------------------------------
`define ALARM_INV_BIT         21
`define ADDR_FIELD_HI         20
`define ADDR_FIELD_LO         16

// ----------------------------------------------------------------------------
// analog flag positions
// ----------------------------------------------------------------------------
`define ANALOG_FLAG_W         14
`define ANALOG_USED_MASK      14'h2bff
`define BIT_OUTPUT_OV         13
`define BIT_CONV_SHORT        11
`define BIT_CONV_REG          9
`define BIT_CAP_MISSING       8
`define BIT_CURR_OPEN         7
`define BIT_VOLT_SHORT        6
`define BIT_CONV_DIE_OT       5
`define BIT_MAIN_DIE_OT       4
`define BIT_REF_OUT           3
`define BIT_REF_IN            2
`define BIT_INT_SUPPLY        1
`define BIT_REG_NODE          0

// ----------------------------------------------------------------------------
// digital flag positions
// ----------------------------------------------------------------------------
`define DIGITAL_FLAG_W        2
`define BIT_FRAME_SLIP        1
`define BIT_CRC_ERR           0

`endif

// File: hw/sticky_flag_cell.v
// row of sticky flags: set by hardware, cleared by writing one
`timescale 1ns/100ps
`default_nettype none

module sticky_flag_cell #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             reset_in,
  input  wire [WIDTH-1:0] set_in,
  input  wire [WIDTH-1:0] clear_in,
  output wire [WIDTH-1:0] flag_out
);

  reg [WIDTH-1:0] flag_r;
  wire [WIDTH-1:0] flag_nxt;

  // a set in the same cycle as a clear wins, so no event is lost
  assign flag_nxt = (flag_r & ~clear_in) | set_in;

  always @(posedge clk_in) begin
    if (reset_in) begin
      flag_r <= {WIDTH{1'b0}};
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule
`default_nettype wire

// File: hw/analog_diag_flag_register.v
// sticky analog and frame-integrity diagnostic flag register bank
//
// Summary of operation
// - set frame slip when msb equals next bit
// - set checksum error on failed frame crc
// - flags stay latched; host writes one to clear
// - disabled diagnostic flags read as zero
// - bit 21 reads inverse of alarm pin
// - analog register 0x15, address field reads back
// - latch bit 13 on output overvoltage
// - latch bit 11 on converter short
// - latch bit 9 on converter regulation fault
// - latch bit 8 on missing regulator capacitor
// - latch bit 7 on open circuit or headroom
// - latch bit 6 on voltage output short
// - bits 5 and 4 independent die overtemperature
// - latch bit 3 on reference output fault
// - latch bit 2 on reference input fault
// - latch bit 1 on internal supply fault
// - latch bit 0 on regulator node fault
// - summary bit ors analog bits 13 to 0
`timescale 1ns/100ps
`default_nettype none
`include "diag_flag_regs.vh"

module analog_diag_flag_register (
  input  wire                          clk_in,
  input  wire                          reset_in,
  // register port
  input  wire [`ADDR_W-1:0]            reg_addr_in,
  input  wire                          reg_wr_in,
  input  wire [`DATA_W-1:0]            reg_wdata_in,
  input  wire                          reg_rd_in,
  output reg  [`DATA_W-1:0]            reg_rdata_out,
  output reg                           reg_rvalid_out,
  // received serial frame check
  input  wire                          frame_done_in,
  input  wire                          frame_msb_in,
  input  wire                          frame_msb_m1_in,
  input  wire                          frame_crc_en_in,
  input  wire                          frame_crc_ok_in,
  // analog supervision levels, high while the fault stands
  input  wire                          output_overvoltage_in,
  input  wire                          converter_short_in,
  input  wire                          converter_regulation_in,
  input  wire                          regulator_cap_missing_in,
  input  wire                          current_open_circuit_in,
  input  wire                          current_headroom_low_in,
  input  wire                          voltage_short_in,
  input  wire                          converter_die_overtemp_in,
  input  wire                          main_die_overtemp_in,
  input  wire                          ref_output_window_in,
  input  wire                          ref_output_limit_in,
  input  wire                          ref_input_node_in,
  input  wire                          internal_supply_node_in,
  input  wire                          regulator_window_in,
  input  wire                          regulator_limit_in,
  // per-bit diagnostic enables, aligned to the flag positions
  input  wire [`ANALOG_FLAG_W-1:0]     analog_diag_en_in,
  // alarm pin level, high while the pin is high
  input  wire                          alarm_pin_in,
  // flag views
  output reg  [`ANALOG_FLAG_W-1:0]     analog_fault_flags_out,
  output reg  [`DIGITAL_FLAG_W-1:0]    digital_fault_flags_out,
  output reg                           analog_summary_bit_out
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire hit_analog;
  wire hit_digital;

  assign hit_analog  = (reg_addr_in == `ANALOG_FLAGS_ADDR);
  assign hit_digital = (reg_addr_in == `DIGITAL_FLAGS_ADDR);

  // --------------------------------------------------------------------------
  // analog fault conditions
  // --------------------------------------------------------------------------
  reg [`ANALOG_FLAG_W-1:0] analog_cond;

  always @* begin
    analog_cond                   = {`ANALOG_FLAG_W{1'b0}};
    analog_cond[`BIT_OUTPUT_OV]   = output_overvoltage_in;
    analog_cond[`BIT_CONV_SHORT]  = converter_short_in;
    analog_cond[`BIT_CONV_REG]    = converter_regulation_in;
    analog_cond[`BIT_CAP_MISSING] = regulator_cap_missing_in;
    analog_cond[`BIT_CURR_OPEN]   = current_open_circuit_in | current_headroom_low_in;
    analog_cond[`BIT_VOLT_SHORT]  = voltage_short_in;
    analog_cond[`BIT_CONV_DIE_OT] = converter_die_overtemp_in;
    analog_cond[`BIT_MAIN_DIE_OT] = main_die_overtemp_in;
    analog_cond[`BIT_REF_OUT]     = ref_output_window_in | ref_output_limit_in;
    analog_cond[`BIT_REF_IN]      = ref_input_node_in;
    analog_cond[`BIT_INT_SUPPLY]  = internal_supply_node_in;
    analog_cond[`BIT_REG_NODE]    = regulator_window_in | regulator_limit_in;
  end

  // --------------------------------------------------------------------------
  // analog sticky flags
  // --------------------------------------------------------------------------
  // a disabled diagnostic neither sets its flag nor shows one left over
  wire [`ANALOG_FLAG_W-1:0] analog_en;
  wire [`ANALOG_FLAG_W-1:0] analog_set;
  wire [`ANALOG_FLAG_W-1:0] analog_clr;
  wire [`ANALOG_FLAG_W-1:0] analog_q;
  wire [`ANALOG_FLAG_W-1:0] analog_vis;

  assign analog_en  = analog_diag_en_in & `ANALOG_USED_MASK;
  assign analog_set = analog_cond & analog_en;
  // write-one clear; a standing condition re-sets in the same cycle
  assign analog_clr = (reg_wr_in && hit_analog) ?
                      reg_wdata_in[`ANALOG_FLAG_W-1:0] : {`ANALOG_FLAG_W{1'b0}};
  assign analog_vis = analog_q & analog_en;

  sticky_flag_cell #(
    .WIDTH (`ANALOG_FLAG_W)
  ) u_analog_flags (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .set_in   (analog_set),
    .clear_in (analog_clr),
    .flag_out (analog_q)
  );

  // --------------------------------------------------------------------------
  // frame integrity flags
  // --------------------------------------------------------------------------
  wire [`DIGITAL_FLAG_W-1:0] digital_set;
  wire [`DIGITAL_FLAG_W-1:0] digital_clr;
  wire [`DIGITAL_FLAG_W-1:0] digital_q;

  assign digital_set[`BIT_FRAME_SLIP] = frame_done_in &
                                        (frame_msb_in == frame_msb_m1_in);
  assign digital_set[`BIT_CRC_ERR]    = frame_done_in & frame_crc_en_in &
                                        ~frame_crc_ok_in;
  assign digital_clr = (reg_wr_in && hit_digital) ?
                       reg_wdata_in[`DIGITAL_FLAG_W-1:0] : {`DIGITAL_FLAG_W{1'b0}};

  sticky_flag_cell #(
    .WIDTH (`DIGITAL_FLAG_W)
  ) u_digital_flags (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .set_in   (digital_set),
    .clear_in (digital_clr),
    .flag_out (digital_q)
  );

  // --------------------------------------------------------------------------
  // read image
  // --------------------------------------------------------------------------
  reg [`DATA_W-1:0] analog_word;
  reg [`DATA_W-1:0] digital_word;
  reg [`DATA_W-1:0] rdata_nxt;

  always @* begin
    analog_word = {`DATA_W{1'b0}};
    analog_word[`ALARM_INV_BIT] = ~alarm_pin_in;
    analog_word[`ADDR_FIELD_HI:`ADDR_FIELD_LO] = `ANALOG_FLAGS_ADDR;
    analog_word[`ANALOG_FLAG_W-1:0] = analog_vis;
  end

  always @* begin
    digital_word = {`DATA_W{1'b0}};
    digital_word[`ALARM_INV_BIT] = ~alarm_pin_in;
    digital_word[`ADDR_FIELD_HI:`ADDR_FIELD_LO] = `DIGITAL_FLAGS_ADDR;
    digital_word[`DIGITAL_FLAG_W-1:0] = digital_q;
  end

  // unmapped addresses read as zero
  always @* begin
    if (hit_analog) begin
      rdata_nxt = analog_word;
    end else if (hit_digital) begin
      rdata_nxt = digital_word;
    end else begin
      rdata_nxt = {`DATA_W{1'b0}};
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out           <= {`DATA_W{1'b0}};
      reg_rvalid_out          <= 1'b0;
      analog_fault_flags_out  <= {`ANALOG_FLAG_W{1'b0}};
      digital_fault_flags_out <= {`DIGITAL_FLAG_W{1'b0}};
      analog_summary_bit_out  <= 1'b0;
    end else begin
      reg_rvalid_out          <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_nxt;
      end
      analog_fault_flags_out  <= analog_vis;
      digital_fault_flags_out <= digital_q;
      analog_summary_bit_out  <= |analog_vis;
    end
  end

endmodule
`default_nettype wire

// File: verification/diag_flag_properties.sv
// concurrent checks on the diagnostic flag bank ports
`timescale 1ns/100ps
`default_nettype none
`include "diag_flag_regs.vh"
module diag_flag_properties (
  input wire logic               clk_in, reset_in,
  input wire logic [`ADDR_W-1:0] reg_addr_in,
  input wire logic               reg_wr_in, reg_rd_in, reg_rvalid_out,
  input wire logic [`DATA_W-1:0] reg_wdata_in, reg_rdata_out,
  input wire logic               frame_done_in, frame_msb_in, frame_msb_m1_in,
  input wire logic               frame_crc_en_in, frame_crc_ok_in, voltage_short_in,
  input wire logic [13:0]        analog_diag_en_in, analog_fault_flags_out,
  input wire logic               alarm_pin_in, analog_summary_bit_out,
  input wire logic [1:0]         digital_fault_flags_out
);
  wire rd15 = reg_rd_in && reg_addr_in == `ANALOG_FLAGS_ADDR;
  wire wr15 = reg_wr_in && reg_addr_in == `ANALOG_FLAGS_ADDR;
  wire clr13 = wr15 && reg_wdata_in[13];
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_summary_or_all:
    assert property (analog_summary_bit_out == |analog_fault_flags_out)
    else $error("summary bit differs from flag or");
  a_read_image:
    assert property (rd15 |=> reg_rvalid_out && reg_rdata_out[21:14] ==
      {!$past(alarm_pin_in), `ANALOG_FLAGS_ADDR, 2'h0}) else $error("bad read image");
  a_reserved_zero:
    assert property (rd15 |=> !reg_rdata_out[12] && !reg_rdata_out[10])
    else $error("reserved bit read as one");
  a_disabled_hidden:
    assert property ((analog_fault_flags_out &
      ~($past(analog_diag_en_in) & `ANALOG_USED_MASK)) == 14'h0)
    else $error("disabled flag visible");
  a_short_sets_flag:
    assert property (voltage_short_in && analog_diag_en_in[6] ##1 analog_diag_en_in[6]
      |=> analog_fault_flags_out[6]) else $error("short flag not set");
  a_flag_stays_set:
    assert property (analog_fault_flags_out[13] && analog_diag_en_in[13] &&
      !$past(clr13) |=> analog_fault_flags_out[13])
    else $error("flag dropped without write");
  a_clear_when_gone:
    assert property (wr15 && reg_wdata_in[6] && !voltage_short_in ##1 !voltage_short_in
      |=> !analog_fault_flags_out[6]) else $error("flag not cleared");
  a_slip_sets_flag:
    assert property (frame_done_in && frame_msb_in == frame_msb_m1_in
      |-> ##2 digital_fault_flags_out[1]) else $error("slip flag not set");
  a_crc_sets_flag:
    assert property (frame_done_in && frame_crc_en_in && !frame_crc_ok_in
      |-> ##2 digital_fault_flags_out[0]) else $error("crc flag not set");
  c_short_seen: cover property (voltage_short_in && analog_diag_en_in[6]);
  c_clear_write: cover property (wr15 && reg_wdata_in[6]);
  c_slip_seen: cover property (digital_fault_flags_out[1]);
endmodule
bind analog_diag_flag_register diag_flag_properties u_props (.*);
`default_nettype wire

// File: verification/host_ctrl.sv
// host controller model issuing register writes and reads
`timescale 1ns/100ps
`default_nettype none
`include "diag_flag_regs.vh"
module host_ctrl (
  input  wire logic               clk_in,
  input  wire logic [`DATA_W-1:0] rdata_in,
  input  wire logic               rvalid_in,
  output var  logic [`ADDR_W-1:0] addr_out = 5'h1f,
  output var  logic               wr_out = 1'b0,
  output var  logic               rd_out = 1'b0,
  output var  logic [`DATA_W-1:0] wdata_out = 22'h0
);
  // idle bus shows the inverse so stale values never pass
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
    int i;
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    d = 'x;
    for (i = 0; i < 4; i++) begin
      #1;
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        break;
      end
      @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/analog_diag_flag_register_tb.sv
// self-checking bench for the diagnostic flag bank
`timescale 1ns/100ps
`default_nettype none
`include "diag_flag_regs.vh"
module analog_diag_flag_register_tb;
  logic        clk_in = 0, reset_in = 1, alarm = 1;
  logic        fdone = 0, fmsb = 1, fm1 = 0, fcen = 1, fcok = 1;
  logic [13:0] flt = 0, en = 14'h3fff;
  logic [2:0]  alt = 0;
  logic [21:0] d;
  wire  [4:0]  addr;
  wire         wr, rd, rvalid, summ;
  wire  [21:0] wdata, rdata;
  wire  [13:0] aflags;
  wire  [1:0]  dflags;
  int          n_mismatch = 0, n_tests = 0;
  always #2.5 clk_in = ~clk_in;
  host_ctrl host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  analog_diag_flag_register dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .frame_done_in(fdone), .frame_msb_in(fmsb),
    .frame_msb_m1_in(fm1), .frame_crc_en_in(fcen), .frame_crc_ok_in(fcok),
    .output_overvoltage_in(flt[13]), .converter_short_in(flt[11]),
    .converter_regulation_in(flt[9]), .regulator_cap_missing_in(flt[8]),
    .current_open_circuit_in(flt[7]), .current_headroom_low_in(alt[0]),
    .voltage_short_in(flt[6]), .converter_die_overtemp_in(flt[5]),
    .main_die_overtemp_in(flt[4]), .ref_output_window_in(flt[3]),
    .ref_output_limit_in(alt[1]), .ref_input_node_in(flt[2]),
    .internal_supply_node_in(flt[1]), .regulator_window_in(flt[0]),
    .regulator_limit_in(alt[2]), .analog_diag_en_in(en), .alarm_pin_in(alarm),
    .analog_fault_flags_out(aflags), .digital_fault_flags_out(dflags),
    .analog_summary_bit_out(summ));
  task automatic chk(input logic [21:0] exp, input logic [21:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fault(input logic [13:0] f, input logic [2:0] g);
    @(posedge clk_in);
    flt <= f;
    alt <= g;
    @(posedge clk_in);
    flt <= 14'h0;
    alt <= 3'h0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic rda(input logic [21:0] exp);
    host.rd(`ANALOG_FLAGS_ADDR, d);
    chk(exp, d);
  endtask
  task automatic t_reset_image;
    rda(`ANALOG_FLAGS_RESET);
    @(posedge clk_in);
    alarm <= 1'b0;
    rda(22'h350000);
    @(posedge clk_in);
    alarm <= 1'b1;
    host.rd(5'h03, d);
    chk(22'h0, d);
  endtask
  task automatic t_flags;
    logic [13:0] m;
    int i;
    for (i = 0; i < 17; i++) begin
      if (i == 10 || i == 12) continue;
      m = (i < 14) ? 14'h1 << i : (i == 14) ? 14'h80 : (i == 15) ? 14'h8 : 14'h1;
      fault((i < 14) ? m : 14'h0, (i < 14) ? 3'h0 : 3'h1 << (i - 14));
      chk({8'h0, m}, {8'h0, aflags});
      chk(22'h1, {21'h0, summ});
      host.wr(`ANALOG_FLAGS_ADDR, ~{8'h0, m});
      rda(`ANALOG_FLAGS_RESET | {8'h0, m});
      host.wr(`ANALOG_FLAGS_ADDR, {8'h0, m});
      rda(`ANALOG_FLAGS_RESET);
      chk(22'h0, {21'h0, summ});
    end
  endtask
  task automatic t_standing;
    @(posedge clk_in);
    flt <= 14'h40;
    host.wr(`ANALOG_FLAGS_ADDR, 22'h40);
    rda(22'h150040);
    @(posedge clk_in);
    flt <= 14'h0;
    host.wr(`ANALOG_FLAGS_ADDR, 22'h40);
    rda(`ANALOG_FLAGS_RESET);
  endtask
  task automatic t_disable;
    fault(14'h10, 3'h0);
    @(posedge clk_in);
    en <= 14'h3fcf;
    fault(14'h20, 3'h0);
    rda(`ANALOG_FLAGS_RESET);
    chk(22'h0, {8'h0, aflags});
    @(posedge clk_in);
    en <= 14'h3fff;
    host.wr(5'h03, 22'h3fffff);
    rda(22'h150010);
    host.wr(`ANALOG_FLAGS_ADDR, 22'h10);
  endtask
  task automatic t_reset_mid;
    fault(14'h2000, 3'h0);
    chk(22'h2000, {8'h0, aflags});
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rda(`ANALOG_FLAGS_RESET);
    chk(22'h0, {8'h0, aflags});
  endtask
  task automatic t_frame(input logic [3:0] v, input logic [1:0] exp);
    @(posedge clk_in);
    {fmsb, fm1, fcen, fcok} <= v;
    fdone <= 1'b1;
    @(posedge clk_in);
    fdone <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({20'h0, exp}, {20'h0, dflags});
    host.rd(`DIGITAL_FLAGS_ADDR, d);
    chk(`DIGITAL_FLAGS_RESET | {20'h0, exp}, d);
    host.wr(`DIGITAL_FLAGS_ADDR, 22'h3);
    host.rd(`DIGITAL_FLAGS_ADDR, d);
    chk(`DIGITAL_FLAGS_RESET, d);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_image();
    t_flags();
    t_standing();
    t_disable();
    t_reset_mid();
    t_frame(4'b1011, 2'h0);
    t_frame(4'b1111, 2'h2);
    t_frame(4'b0001, 2'h2);
    t_frame(4'b1010, 2'h1);
    t_frame(4'b1000, 2'h0);
    tally_and_finish();
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
